// ### hw/atrf_pkg.sv
package atrf_pkg;
    // Register pointer, reset and unmapped-read values
    localparam logic [7:0]  ATRF_PTR_AMBIENT   = 8'h05;
    localparam logic [15:0] ATRF_AMBIENT_RESET = 16'h0000;
    localparam logic [15:0] ATRF_UNMAPPED_READ = 16'h0000;

    // Result word layout
    localparam int ATRF_BIT_CRIT  = 15;
    localparam int ATRF_BIT_UPPER = 14;
    localparam int ATRF_BIT_LOWER = 13;
    localparam int ATRF_BIT_SIGN  = 12;
    localparam int ATRF_TEMP_W    = 13;

    // Limit word layout: signed quarter-degree field, two low bits implied zero
    localparam int ATRF_LIM_MSB = 12;
    localparam int ATRF_LIM_LSB = 2;

    // Resolution codes and low-bit masks
    localparam logic [1:0] ATRF_RES_HALF      = 2'h0;
    localparam logic [1:0] ATRF_RES_QUARTER   = 2'h1;
    localparam logic [1:0] ATRF_RES_EIGHTH    = 2'h2;
    localparam logic [1:0] ATRF_RES_SIXTEENTH = 2'h3;
    localparam logic [2:0] ATRF_MASK_HALF      = 3'h7;
    localparam logic [2:0] ATRF_MASK_QUARTER   = 3'h3;
    localparam logic [2:0] ATRF_MASK_EIGHTH    = 3'h1;
    localparam logic [2:0] ATRF_MASK_SIXTEENTH = 3'h0;

    // Serial framing
    localparam logic [3:0] ATRF_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ATRF_MSB_INDEX     = 4'h7;

    typedef enum logic [4:0] {
        ATRF_IDLE    = 5'h01,
        ATRF_RX      = 5'h02,
        ATRF_ACK_OUT = 5'h04,
        ATRF_TX      = 5'h08,
        ATRF_ACK_IN  = 5'h10
    } atrf_state_t;

    typedef enum logic [2:0] {
        ATRF_PH_ADDR  = 3'h1,
        ATRF_PH_PTR   = 3'h2,
        ATRF_PH_WDATA = 3'h4
    } atrf_phase_t;
endpackage

// ### hw/atrf_word_if.sv
`timescale 1ns/1ps
interface atrf_word_if;
    logic        capture;
    logic [15:0] word;
    modport serial (output capture, input word);
    modport result (input capture, output word);
endinterface

// ### hw/atrf_result.sv
`timescale 1ns/1ps
module atrf_result
    import atrf_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic [ATRF_TEMP_W-1:0] conv_data,
    input  wire logic                   conv_valid,
    input  wire logic [1:0]             res_sel,
    input  wire logic [15:0]            critical_limit,
    input  wire logic [15:0]            upper_window_limit,
    input  wire logic [15:0]            lower_window_limit,
    atrf_word_if.result                 wif
);
    logic        [15:0]            live;
    logic        [15:0]            snap;
    logic        [15:0]            next_live;
    logic        [15:0]            next_snap;
    logic        [2:0]             low_mask;
    logic signed [ATRF_TEMP_W-1:0] temp;
    logic signed [ATRF_TEMP_W-1:0] crit_ext;
    logic signed [ATRF_TEMP_W-1:0] upper_ext;
    logic signed [ATRF_TEMP_W-1:0] lower_ext;

    always_comb begin
        unique case (res_sel)
            ATRF_RES_HALF:      low_mask = ATRF_MASK_HALF;
            ATRF_RES_QUARTER:   low_mask = ATRF_MASK_QUARTER;
            ATRF_RES_EIGHTH:    low_mask = ATRF_MASK_EIGHTH;
            ATRF_RES_SIXTEENTH: low_mask = ATRF_MASK_SIXTEENTH;
        endcase
        temp      = signed'({conv_data[ATRF_TEMP_W-1:3], conv_data[2:0] & ~low_mask});
        crit_ext  = signed'({critical_limit[ATRF_LIM_MSB:ATRF_LIM_LSB], 2'h0});
        upper_ext = signed'({upper_window_limit[ATRF_LIM_MSB:ATRF_LIM_LSB], 2'h0});
        lower_ext = signed'({lower_window_limit[ATRF_LIM_MSB:ATRF_LIM_LSB], 2'h0});
        next_live = live;
        next_snap = snap;
        if (conv_valid) begin
            // bits 11:0 carry 2^7 down to 2^-4
            next_live[ATRF_TEMP_W-1:0] = temp;
            // sign is bit 12 of the field
            next_live[ATRF_BIT_SIGN] = temp[ATRF_TEMP_W-1];
            next_live[ATRF_BIT_CRIT]  = (temp >= crit_ext);
            next_live[ATRF_BIT_UPPER] = (temp > upper_ext);
            next_live[ATRF_BIT_LOWER] = (temp < lower_ext);
        end
        // frozen copy for a read in progress
        if (wif.capture) begin
            next_snap = live;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            live <= ATRF_AMBIENT_RESET;
            snap <= ATRF_AMBIENT_RESET;
        end else begin
            live <= next_live;
            snap <= next_snap;
        end
    end

    assign wif.word = snap;
endmodule

// ### hw/atrf_top.sv
`timescale 1ns/1ps
module atrf_top
    import atrf_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    input  wire logic                   scl,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    input  wire logic [6:0]             slave_addr,
    input  wire logic [ATRF_TEMP_W-1:0] conv_data,
    input  wire logic                   conv_valid,
    input  wire logic [1:0]             res_sel,
    input  wire logic [15:0]            critical_limit,
    input  wire logic [15:0]            upper_window_limit,
    input  wire logic [15:0]            lower_window_limit
);
    atrf_word_if wif ();

    atrf_result u_result (
        .clk_sys            (clk_sys),
        .rstn               (rstn),
        .conv_data          (conv_data),
        .conv_valid         (conv_valid),
        .res_sel            (res_sel),
        .critical_limit     (critical_limit),
        .upper_window_limit (upper_window_limit),
        .lower_window_limit (lower_window_limit),
        .wif                (wif.result)
    );

    atrf_state_t state;
    atrf_state_t next_state;
    atrf_phase_t phase;
    atrf_phase_t next_phase;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic [7:0]  pointer;
    logic [7:0]  next_pointer;
    logic        rw;
    logic        next_rw;
    logic        byte_hi;
    logic        next_byte_hi;
    logic        acked;
    logic        next_acked;
    logic        next_oe;
    logic        capture;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic [15:0] tx_word;
    logic [7:0]  tx_byte;
    logic [7:0]  low_byte;
    logic [2:0]  bit_idx;

    assign scl_rise   = scl & ~scl_q;
    assign scl_fall   = ~scl & scl_q;
    assign start_cond = scl & scl_q & sda_q & ~sda_in;
    assign stop_cond  = scl & scl_q & ~sda_q & sda_in;
    // Other pointers are outside this block and read as zero
    assign tx_word    = (pointer == ATRF_PTR_AMBIENT) ? wif.word : ATRF_UNMAPPED_READ;
    assign low_byte   = tx_word[7:0];
    assign tx_byte    = byte_hi ? tx_word[15:8] : low_byte;
    assign bit_idx    = 3'(ATRF_MSB_INDEX - cnt);
    assign wif.capture = capture;
    // Open drain: only ever pulls low
    assign sda_out    = 1'b0;

    always_comb begin
        next_state   = state;
        next_phase   = phase;
        next_cnt     = cnt;
        next_shreg   = shreg;
        next_pointer = pointer;
        next_rw      = rw;
        next_byte_hi = byte_hi;
        next_acked   = acked;
        next_oe      = sda_oe;
        capture      = 1'b0;
        if (start_cond) begin
            next_state = ATRF_RX;
            next_phase = ATRF_PH_ADDR;
            next_cnt   = 4'h0;
            next_oe    = 1'b0;
        end else if (stop_cond) begin
            next_state = ATRF_IDLE;
            next_oe    = 1'b0;
        end else begin
            unique case (state)
                ATRF_IDLE: begin
                    next_oe = 1'b0;
                end
                ATRF_RX: begin
                    if (scl_rise && cnt != ATRF_BITS_PER_BYTE) begin
                        next_shreg = {shreg[6:0], sda_in};
                        next_cnt   = cnt + 4'h1;
                    end else if (scl_fall && cnt == ATRF_BITS_PER_BYTE) begin
                        unique case (phase)
                            ATRF_PH_ADDR: begin
                                if (shreg[7:1] == slave_addr) begin
                                    next_rw    = shreg[0];
                                    next_oe    = 1'b1;
                                    next_state = ATRF_ACK_OUT;
                                    // freeze word for the whole read
                                    capture    = shreg[0];
                                end else begin
                                    next_state = ATRF_IDLE;
                                end
                            end
                            ATRF_PH_PTR: begin
                                next_pointer = shreg;
                                next_phase   = ATRF_PH_WDATA;
                                next_oe      = 1'b1;
                                next_state   = ATRF_ACK_OUT;
                            end
                            ATRF_PH_WDATA: begin
                                next_oe    = 1'b1;
                                next_state = ATRF_ACK_OUT;
                            end
                        endcase
                    end
                end
                ATRF_ACK_OUT: begin
                    if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (phase == ATRF_PH_ADDR && rw) begin
                            next_byte_hi = 1'b1;
                            next_state   = ATRF_TX;
                            next_oe      = ~tx_word[15];
                        end else begin
                            next_oe    = 1'b0;
                            next_state = ATRF_RX;
                            if (phase == ATRF_PH_ADDR) begin
                                next_phase = ATRF_PH_PTR;
                            end
                        end
                    end
                end
                ATRF_TX: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == ATRF_BITS_PER_BYTE) begin
                            next_oe    = 1'b0;
                            next_state = ATRF_ACK_IN;
                        end else begin
                            next_oe = ~tx_byte[bit_idx];
                        end
                    end
                end
                ATRF_ACK_IN: begin
                    if (scl_rise) begin
                        next_acked = ~sda_in;
                    end else if (scl_fall) begin
                        if (acked) begin
                            next_byte_hi = ~byte_hi;
                            next_cnt     = 4'h0;
                            next_state   = ATRF_TX;
                            next_oe      = byte_hi ? ~low_byte[7] : ~tx_word[15];
                        end else begin
                            next_state = ATRF_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state   <= ATRF_IDLE;
            phase   <= ATRF_PH_ADDR;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            cnt     <= 4'h0;
            shreg   <= 8'h00;
            pointer <= 8'h00;
            rw      <= 1'b0;
            byte_hi <= 1'b1;
            acked   <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            state   <= next_state;
            phase   <= next_phase;
            scl_q   <= scl;
            sda_q   <= sda_in;
            cnt     <= next_cnt;
            shreg   <= next_shreg;
            pointer <= next_pointer;
            rw      <= next_rw;
            byte_hi <= next_byte_hi;
            acked   <= next_acked;
            sda_oe  <= next_oe;
        end
    end
endmodule

// ### verif/atrf_top_checker.sv
`timescale 1ns/1ps
module atrf_top_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic conv_valid
);
    logic scl_q;
    logic sda_q;
    logic busy;
    logic next_busy;
    logic start_ev;
    logic stop_ev;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    assign start_ev = scl && scl_q && sda_q && !sda_in;
    assign stop_ev  = scl && scl_q && !sda_q && sda_in;

    // Bus owned from start to stop
    always_comb begin
        next_busy = start_ev ? 1'b1 : (stop_ev ? 1'b0 : busy);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            busy  <= 1'b0;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
            busy  <= next_busy;
        end
    end

    a_drive_low: assert property (sda_out == 1'b0)
        else $error("sda output level not low");
    a_high_stable: assert property (scl && scl_q |-> $stable(sda_oe))
        else $error("sda drive moved while clock high");
    a_change_low: assert property ($changed(sda_oe) |-> !$past(scl) && !scl)
        else $error("sda drive moved while clock not low");
    a_oe_stands: assert property ($rose(sda_oe) |-> sda_oe [*3])
        else $error("sda drive released early");
    a_start_free: assert property (start_ev |-> !sda_oe)
        else $error("device drives at start");
    a_stop_free: assert property (stop_ev |-> !sda_oe)
        else $error("device drives at stop");
    a_idle_quiet: assert property (!busy |-> !sda_oe)
        else $error("device drives idle bus");
    a_load_clean: assert property (conv_valid && scl ##1 scl |-> $stable(sda_oe))
        else $error("load disturbed a bit in flight");

    c_start: cover property (start_ev);
    c_ack: cover property ($rose(sda_oe));
    c_load: cover property (conv_valid && busy);
    c_stop: cover property (stop_ev);
endmodule

bind atrf_top atrf_top_checker chk (.clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .conv_valid(conv_valid));

// ### verif/atrf_host.sv
`timescale 1ns/1ps
module atrf_host (
    input  wire logic clk_sys,
    input  wire logic sda,
    output logic      scl,
    output logic      pull_low
);
    // Clock stands high between frames, data left to the pull-up
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic put_bit(input logic b);
        hold(1);
        pull_low <= !b;
        hold(3);
        scl <= 1'b1;
        hold(4);
        scl <= 1'b0;
    endtask

    task automatic get_bit(output logic b);
        pull_low <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(2);
        b = sda;
        hold(2);
        scl <= 1'b0;
    endtask

    task automatic start();
        hold(1);
        pull_low <= 1'b0;
        hold(4);
        scl <= 1'b1;
        hold(4);
        pull_low <= 1'b1;
        hold(4);
        scl <= 1'b0;
    endtask

    task automatic stop();
        hold(1);
        pull_low <= 1'b1;
        hold(4);
        scl <= 1'b1;
        hold(4);
        pull_low <= 1'b0;
        hold(4);
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask

    // acknowledge first byte, refuse the last
    task automatic recv(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask
endmodule

// ### verif/atrf_top_tb.sv
`timescale 1ns/1ps
module atrf_top_tb;
    import atrf_pkg::*;
    logic                   clk_sys, rstn, scl, sda_in, sda_out, sda_oe, pull_low, conv_valid;
    logic [6:0]             slave_addr;
    logic [ATRF_TEMP_W-1:0] conv_data;
    logic [1:0]             res_sel;
    logic [15:0]            critical_limit, upper_window_limit, lower_window_limit, w;
    logic [2:0]             k;
    int                     failures, checked;

    assign sda_in = (sda_oe ? sda_out : 1'b1) & !pull_low;

    atrf_top uut (.clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .slave_addr(slave_addr), .conv_data(conv_data), .conv_valid(conv_valid),
        .res_sel(res_sel), .critical_limit(critical_limit), .upper_window_limit(upper_window_limit),
        .lower_window_limit(lower_window_limit));
    atrf_host host (.clk_sys(clk_sys), .sda(sda_in), .scl(scl), .pull_low(pull_low));

    always #25 clk_sys = ~clk_sys;

    task automatic judge(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic load(input logic [12:0] t, input logic [1:0] r, input logic [15:0] c, u, l);
        res_sel <= r;
        critical_limit <= c;
        upper_window_limit <= u;
        lower_window_limit <= l;
        conv_data <= t;
        conv_valid <= 1'b1;
        @(posedge clk_sys);
        conv_valid <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic access(input logic [7:0] ptr, input logic [6:0] a, input logic mid);
        host.start();
        host.send({a, 1'b0}, k[2]);
        host.send(ptr, k[1]);
        host.start();
        host.send({a, 1'b1}, k[0]);
        if (mid) load(13'h0320, ATRF_RES_SIXTEENTH, 16'h0640, 16'h0500, 16'h1F00);
        host.recv(w[15:8], 1'b0);
        host.recv(w[7:0], 1'b1);
        host.stop();
    endtask

    task automatic expect_read(input logic [15:0] exp);
        access(ATRF_PTR_AMBIENT, slave_addr, 1'b0);
        judge(w, exp);
        judge({13'h0000, k}, 16'h0007);
    endtask

    task automatic t_codes();
        expect_read(ATRF_AMBIENT_RESET);
        load(13'h01F3, ATRF_RES_SIXTEENTH, 16'h01F0, 16'h0200, 16'h0100);
        expect_read(16'h81F3);
        load(13'h1EBB, ATRF_RES_QUARTER, 16'h0640, 16'h0500, 16'h1F00);
        expect_read(16'h3EB8);
        load(13'h0467, ATRF_RES_HALF, 16'h0640, 16'h0460, 16'h0100);
        expect_read(16'h0460);
        load(13'h0C81, ATRF_RES_EIGHTH, 16'h0C80, 16'h0500, 16'h0100);
        expect_read(16'hCC80);
    endtask

    task automatic t_refusals();
        access(8'h03, slave_addr, 1'b0);
        judge(w, ATRF_UNMAPPED_READ);
        access(ATRF_PTR_AMBIENT, slave_addr ^ 7'h01, 1'b0);
        judge({13'h0000, k}, 16'h0000);
    endtask

    task automatic t_write();
        logic [3:0] a;
        host.start();
        host.send({slave_addr, 1'b0}, a[3]);
        host.send(ATRF_PTR_AMBIENT, a[2]);
        host.send(8'hFF, a[1]);
        host.send(8'h00, a[0]);
        host.stop();
        judge({12'h000, a}, 16'h000F);
        expect_read(16'hCC80);
    endtask

    task automatic t_buffer();
        load(13'h0190, ATRF_RES_SIXTEENTH, 16'h0640, 16'h0500, 16'h1F00);
        access(ATRF_PTR_AMBIENT, slave_addr, 1'b1);
        judge(w, 16'h0190);
        expect_read(16'h0320);
    endtask

    task automatic conclude();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        failures++;
        $display("unexpected at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        clk_sys = 1'b0;
        rstn = 1'b0;
        slave_addr = 7'h18;
        conv_data = '0;
        conv_valid = 1'b0;
        res_sel = ATRF_RES_QUARTER;
        critical_limit = 16'h0000;
        upper_window_limit = 16'h0000;
        lower_window_limit = 16'h0000;
        failures = 0;
        checked = 0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_codes();
        t_refusals();
        t_write();
        t_buffer();
        conclude();
    end
endmodule
